// [rtl/converter_pair_control.sv]
// Top of the converter pair rate and mute control block.
// Assumes core_run and vol_bypass come from logic on ref_clk, so they are not synchronised.
//
// Summary of operation
// - Order bit per pair: zero picks fourth-order sinc, one picks third-order.
// - Filter order changes only while the core run flag is zero.
// - Per-channel mute forces full attenuation; mutes come out of reset set.
// - With volume stage bypassed, the channel's mute has no effect.
// - Two-bit rate: 00 is 96 kHz, 01 is 192 kHz, 10 is 768 kHz, 11 reserved.
// - Rate updates only while core is stopped; software keeps it matching path rate.
// - Pair 0/1 register at offset 0x1B, reset 0x19.
// - Pair 2/3 register at offset 0x1C, same layout and reset.
`timescale 1ns/1ns
`default_nettype none
module converter_pair_control
    import converter_pair_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [REG_ADDR_W-1:0] reg_addr,
    input  wire logic [REG_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [REG_DATA_W-1:0] reg_rdata,
    output var  logic                  reg_rvalid,
    input  wire logic                  core_run,
    input  wire logic [3:0]            vol_bypass,
    output var  logic                  pair01_sinc_third,
    output var  logic                  pair23_sinc_third,
    output var  logic [1:0]            pair01_rate_select,
    output var  logic [1:0]            pair23_rate_select,
    output var  logic                  chan0_mute,
    output var  logic                  chan1_mute,
    output var  logic                  chan2_mute,
    output var  logic                  chan3_mute,
    output var  logic [3:0]            force_max_atten
);

    pair_cfg_if p01 ();
    pair_cfg_if p23 ();

    logic                  wr01;
    logic                  wr23;
    logic [REG_DATA_W-1:0] word01;
    logic [REG_DATA_W-1:0] word23;
    logic [3:0]            mute_all;
    logic [REG_DATA_W-1:0] next_rdata;
    logic                  next_rvalid;
    logic [3:0]            next_atten;

    assign wr01 = reg_wr && (reg_addr == PAIR01_CONTROL_ADDR);
    assign wr23 = reg_wr && (reg_addr == PAIR23_CONTROL_ADDR);

    pair_control_reg u_pair01
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .wr_en    (wr01),
        .wdata    (reg_wdata),
        .core_run (core_run),
        .cfg      (p01.owner)
    );

    pair_control_reg u_pair23
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .wr_en    (wr23),
        .wdata    (reg_wdata),
        .core_run (core_run),
        .cfg      (p23.owner)
    );

    // Reserved bits are not stored, so they always read back zero
    assign word01   = pack_control(p01.order, p01.mute, p01.rate);
    assign word23   = pack_control(p23.order, p23.mute, p23.rate);
    assign mute_all = {p23.mute, p01.mute};

    always_comb
    begin
        next_rdata  = READ_UNMAPPED;
        next_rvalid = reg_rd;
        if (reg_rd)
        begin
            case (reg_addr)
                PAIR01_CONTROL_ADDR: next_rdata = word01;
                PAIR23_CONTROL_ADDR: next_rdata = word23;
                default:             next_rdata = READ_UNMAPPED;
            endcase
        end
        // Bypassed volume stage ignores the mute request
        next_atten = mute_all & ~vol_bypass;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            reg_rdata       <= READ_UNMAPPED;
            reg_rvalid      <= 1'b0;
            force_max_atten <= 4'h0;
        end
        else
        begin
            reg_rdata       <= next_rdata;
            reg_rvalid      <= next_rvalid;
            force_max_atten <= next_atten;
        end
    end

    // These come straight from the pair flip-flops
    assign pair01_sinc_third  = p01.order;
    assign pair23_sinc_third  = p23.order;
    assign pair01_rate_select = p01.rate;
    assign pair23_rate_select = p23.rate;
    assign chan0_mute         = p01.mute[0];
    assign chan1_mute         = p01.mute[1];
    assign chan2_mute         = p23.mute[0];
    assign chan3_mute         = p23.mute[1];

    property p_order_update;
        @(posedge ref_clk) disable iff (!rst_n)
        wr01 && !core_run |=> pair01_sinc_third == $past(reg_wdata[ORDER_BIT]);
    endproperty
    a_order_update: assert property (p_order_update)
        else $error("pair 0/1 order did not follow write");

    property p_order_frozen;
        @(posedge ref_clk) disable iff (!rst_n)
        core_run |=> $stable(pair01_sinc_third) && $stable(pair23_sinc_third);
    endproperty
    a_order_frozen: assert property (p_order_frozen)
        else $error("filter order changed while core running");

    property p_mute_atten;
        @(posedge ref_clk) disable iff (!rst_n)
        (mute_all[2] && !vol_bypass[2]) |=> force_max_atten[2];
    endproperty
    a_mute_atten: assert property (p_mute_atten)
        else $error("muted channel 2 not attenuated");

    property p_mute_write;
        @(posedge ref_clk) disable iff (!rst_n)
        wr01 |=> {chan1_mute, chan0_mute} == $past(reg_wdata[MUTE_HI:MUTE_LO]);
    endproperty
    a_mute_write: assert property (p_mute_write)
        else $error("mute bits did not follow write");

    property p_bypass_no_mute;
        @(posedge ref_clk) disable iff (!rst_n)
        vol_bypass[0] |=> !force_max_atten[0];
    endproperty
    a_bypass_no_mute: assert property (p_bypass_no_mute)
        else $error("bypassed channel 0 attenuated");

    property p_rate_never_reserved;
        @(posedge ref_clk) disable iff (!rst_n)
        pair01_rate_select != RATE_RESERVED && pair23_rate_select != RATE_RESERVED;
    endproperty
    a_rate_never_reserved: assert property (p_rate_never_reserved)
        else $error("reserved rate code held");

    property p_rate_frozen;
        @(posedge ref_clk) disable iff (!rst_n)
        core_run |=> $stable(pair01_rate_select) && $stable(pair23_rate_select);
    endproperty
    a_rate_frozen: assert property (p_rate_frozen)
        else $error("rate changed while core running");

    property p_reset_pair01;
        @(posedge ref_clk)
        !rst_n |=> word01 == PAIR_CONTROL_RESET && reg_rvalid == 1'b0;
    endproperty
    a_reset_pair01: assert property (p_reset_pair01)
        else $error("pair 0/1 reset value wrong");

    property p_pair23_layout;
        @(posedge ref_clk) disable iff (!rst_n)
        wr23 && !core_run && reg_wdata[RATE_HI:RATE_LO] != RATE_RESERVED
        |=> word23 == ($past(reg_wdata) & FIELD_MASK);
    endproperty
    a_pair23_layout: assert property (p_pair23_layout)
        else $error("pair 2/3 write layout wrong");

    property p_reset_pair23;
        @(posedge ref_clk)
        !rst_n |=> word23 == PAIR_CONTROL_RESET;
    endproperty
    a_reset_pair23: assert property (p_reset_pair23)
        else $error("pair 2/3 reset value wrong");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid && (reg_rdata & RESERVED_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read non-zero");

    property p_cov_blocked_write;
        @(posedge ref_clk) disable iff (!rst_n)
        wr01 && core_run;
    endproperty
    c_cov_blocked_write: cover property (p_cov_blocked_write);

    property p_cov_reserved_rate;
        @(posedge ref_clk) disable iff (!rst_n)
        wr23 && !core_run && reg_wdata[RATE_HI:RATE_LO] == RATE_RESERVED;
    endproperty
    c_cov_reserved_rate: cover property (p_cov_reserved_rate);

    property p_cov_unmute;
        @(posedge ref_clk) disable iff (!rst_n)
        force_max_atten[1] ##1 !force_max_atten[1];
    endproperty
    c_cov_unmute: cover property (p_cov_unmute);

    property p_cov_read23;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == PAIR23_CONTROL_ADDR;
    endproperty
    c_cov_read23: cover property (p_cov_read23);

endmodule
`default_nettype wire

// [rtl/converter_pair_pkg.sv]
// Package for the converter pair rate and mute control block.
// Assumes an 8-bit register port clocked by ref_clk with a synchronous reset.
`default_nettype none
package converter_pair_pkg;

    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned REG_DATA_W = 8;

    localparam logic [REG_ADDR_W-1:0] PAIR01_CONTROL_ADDR = 8'h1b;
    localparam logic [REG_ADDR_W-1:0] PAIR23_CONTROL_ADDR = 8'h1c;
    localparam logic [REG_DATA_W-1:0] PAIR_CONTROL_RESET  = 8'h19;
    localparam logic [REG_DATA_W-1:0] FIELD_MASK          = 8'h3b;
    localparam logic [REG_DATA_W-1:0] RESERVED_MASK       = 8'hc4;
    localparam logic [REG_DATA_W-1:0] READ_UNMAPPED       = 8'h00;

    localparam int unsigned ORDER_BIT = 5;
    localparam int unsigned MUTE_HI   = 4;
    localparam int unsigned MUTE_LO   = 3;
    localparam int unsigned RATE_HI   = 1;
    localparam int unsigned RATE_LO   = 0;

    typedef enum logic
    {
        SINC4 = 1'b0,
        SINC3 = 1'b1
    } sinc_order_t;

    typedef enum logic [1:0]
    {
        RATE_96K      = 2'b00,
        RATE_192K     = 2'b01,
        RATE_768K     = 2'b10,
        RATE_RESERVED = 2'b11
    } rate_sel_t;

    localparam sinc_order_t ORDER_RESET = SINC4;
    localparam logic [1:0]  MUTE_RESET  = 2'b11;
    localparam rate_sel_t   RATE_RESET  = RATE_192K;

    function automatic logic [REG_DATA_W-1:0] pack_control(
        input sinc_order_t order,
        input logic [1:0]  mute,
        input rate_sel_t   rate
    );
        logic [REG_DATA_W-1:0] word;
        word = 8'h00;
        word[ORDER_BIT] = order;
        word[MUTE_HI:MUTE_LO] = mute;
        word[RATE_HI:RATE_LO] = rate;
        return word;
    endfunction

endpackage
`default_nettype wire

// [rtl/pair_cfg_if.sv]
// Interface carrying one converter pair's live settings.
// Assumes one owner drives it and the top module reads it.
`timescale 1ns/1ns
`default_nettype none
interface pair_cfg_if;
    import converter_pair_pkg::*;

    sinc_order_t order;
    logic [1:0]  mute;
    rate_sel_t   rate;

    modport owner (output order, output mute, output rate);
    modport user  (input order, input mute, input rate);
endinterface
`default_nettype wire

// [rtl/pair_control_reg.sv]
// Control register of one converter pair: filter order, two mutes, rate.
// Assumes wr_en is already decoded and core_run is on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module pair_control_reg
    import converter_pair_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  wr_en,
    input  wire logic [REG_DATA_W-1:0] wdata,
    input  wire logic                  core_run,
    pair_cfg_if.owner                  cfg
);

    sinc_order_t order;
    logic [1:0]  mute;
    rate_sel_t   rate;
    sinc_order_t next_order;
    logic [1:0]  next_mute;
    rate_sel_t   next_rate;
    rate_sel_t   wr_rate;

    assign wr_rate = rate_sel_t'(wdata[RATE_HI:RATE_LO]);

    always_comb
    begin
        next_order = order;
        next_mute  = mute;
        next_rate  = rate;
        if (wr_en)
        begin
            next_mute = wdata[MUTE_HI:MUTE_LO];
            // Order and rate would glitch a running decimator
            if (!core_run)
            begin
                next_order = sinc_order_t'(wdata[ORDER_BIT]);
                // Reserved rate code is dropped, old rate kept
                if (wr_rate != RATE_RESERVED)
                begin
                    next_rate = wr_rate;
                end
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            order <= ORDER_RESET;
            mute  <= MUTE_RESET;
            rate  <= RATE_RESET;
        end
        else
        begin
            order <= next_order;
            mute  <= next_mute;
            rate  <= next_rate;
        end
    end

    assign cfg.order = order;
    assign cfg.mute  = mute;
    assign cfg.rate  = rate;

endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the converter pair rate and mute control block.
// Assumes the design top converter_pair_control and its package; drives its register port directly.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import converter_pair_pkg::*;

    logic                  ref_clk;
    logic                  rst_n;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [REG_DATA_W-1:0] reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [REG_DATA_W-1:0] reg_rdata;
    logic                  reg_rvalid;
    logic                  core_run;
    logic [3:0]            vol_bypass;
    logic                  pair01_sinc_third;
    logic                  pair23_sinc_third;
    logic [1:0]            pair01_rate_select;
    logic [1:0]            pair23_rate_select;
    logic                  chan0_mute;
    logic                  chan1_mute;
    logic                  chan2_mute;
    logic                  chan3_mute;
    logic [3:0]            force_max_atten;
    int                    fails;
    int                    compares;

    converter_pair_control dut
    (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .reg_rvalid         (reg_rvalid),
        .core_run           (core_run),
        .vol_bypass         (vol_bypass),
        .pair01_sinc_third  (pair01_sinc_third),
        .pair23_sinc_third  (pair23_sinc_third),
        .pair01_rate_select (pair01_rate_select),
        .pair23_rate_select (pair23_rate_select),
        .chan0_mute         (chan0_mute),
        .chan1_mute         (chan1_mute),
        .chan2_mute         (chan2_mute),
        .chan3_mute         (chan3_mute),
        .force_max_atten    (force_max_atten)
    );

    always #10 ref_clk = ~ref_clk;

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Write strobe held for exactly one edge; fields visible once it returns
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
        chk("rdata", reg_rdata, exp);
    endtask

    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
    endtask

    initial
    begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end

    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        core_run = 1'b0;
        vol_bypass = 4'h0;
        fails = 0;
        compares = 0;
        do_reset();
        rd(PAIR01_CONTROL_ADDR, 8'h19);
        rd(PAIR23_CONTROL_ADDR, 8'h19);
        chk("mutes", {4'h0, chan3_mute, chan2_mute, chan1_mute, chan0_mute}, 8'h0f);
        chk("atten", {4'h0, force_max_atten}, 8'h0f);
        chk("rate01", {6'h00, pair01_rate_select}, 8'h01);
        chk("sinc", {6'h00, pair23_sinc_third, pair01_sinc_third}, 8'h00);
        $display("test reset values done");

        // Reserved bits set on purpose; code 11 must leave the previous rate
        for (int r = 0; r < 4; r++)
        begin
            wr(PAIR01_CONTROL_ADDR, 8'hec | 8'(r));
            chk("rate01", {6'h00, pair01_rate_select}, (r < 3) ? 8'(r) : 8'h02);
            chk("sinc01", {7'h00, pair01_sinc_third}, 8'h01);
            rd(PAIR01_CONTROL_ADDR, (r < 3) ? (8'h28 | 8'(r)) : 8'h2a);
        end
        settle();
        chk("atten", {4'h0, force_max_atten}, 8'h0d);
        $display("test rate codes done");

        @(posedge ref_clk);
        core_run <= 1'b1;
        wr(PAIR01_CONTROL_ADDR, 8'h19);
        chk("sinc01", {7'h00, pair01_sinc_third}, 8'h01);
        chk("rate01", {6'h00, pair01_rate_select}, 8'h02);
        rd(PAIR01_CONTROL_ADDR, 8'h3a);
        // Mutes still land while running; order and rate of pair 2/3 stay
        wr(PAIR23_CONTROL_ADDR, 8'h22);
        rd(PAIR23_CONTROL_ADDR, 8'h01);
        @(posedge ref_clk);
        core_run <= 1'b0;
        $display("test core running done");

        wr(PAIR23_CONTROL_ADDR, 8'h22);
        chk("pair23", {3'h0, pair23_sinc_third, chan3_mute, chan2_mute, pair23_rate_select}, 8'h12);
        rd(PAIR23_CONTROL_ADDR, 8'h22);
        settle();
        chk("atten", {4'h0, force_max_atten}, 8'h03);
        wr(PAIR23_CONTROL_ADDR, 8'h18);
        for (int b = 0; b < 16; b++)
        begin
            @(posedge ref_clk);
            vol_bypass <= 4'(b);
            settle();
            settle();
            chk("atten", {4'h0, force_max_atten}, {4'h0, ~4'(b)});
        end
        @(posedge ref_clk);
        vol_bypass <= 4'h0;
        // Reserved rate on pair 2/3: rate kept, order and mutes taken
        wr(PAIR23_CONTROL_ADDR, 8'h3b);
        chk("rate23", {6'h00, pair23_rate_select}, 8'h00);
        rd(PAIR23_CONTROL_ADDR, 8'h38);
        $display("test mute and bypass done");

        wr(8'h1d, 8'hff);
        rd(8'h1d, READ_UNMAPPED);
        rd(PAIR01_CONTROL_ADDR, 8'h3a);
        rd(PAIR23_CONTROL_ADDR, 8'h38);
        settle();
        chk("rvalid", {7'h00, reg_rvalid}, 8'h00);
        $display("test unmapped done");

        @(posedge ref_clk);
        do_reset();
        rd(PAIR01_CONTROL_ADDR, 8'h19);
        rd(PAIR23_CONTROL_ADDR, 8'h19);
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
